// ==== hdl/fpt_host.sv ====
// file: host controller driving a flash through its pins across power transitions
//
// Summary of operation
// - host keeps supplies and reset valid
// - host reports an abort after supply loss in the busy wait and returns to sleep, without reissuing the sequence
// - host issues read-array at the start of every read, not at the end of write or erase
// - host waits wake-up delays before access after a wake from sleep, not after a supply dip outside the busy wait
// - read-array command code is ffh
`timescale 1ns/10ps
`default_nettype none
module fpt_host (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // user side
    input  wire logic                 req_valid,
    input  wire fpt_pkg::fpt_req_type req,
    input  wire logic                 supply_ok,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output fpt_pkg::fpt_rsp_type      rsp,
    // flash pins
    output logic [17:0]               fl_addr,
    input  wire logic [15:0]          fl_dq_in,
    output logic [15:0]               fl_dq_out,
    output logic                      fl_dq_oe,
    output logic                      fl_chip_en_n,
    output logic                      fl_write_en_n,
    output logic                      fl_out_en_n,
    output logic                      reset_powerdown_n,
    input  wire logic                 ready_busy_n
);
    ////////////////////////////////////////////////////////////////////////
    // state machine
    typedef enum logic [3:0] {
        st_wake_wait = 4'b0000, // after reset release, wait wake-up
        st_idle      = 4'b0001,
        st_wr_low    = 4'b0010, // bus write strobe low
        st_wr_high   = 4'b0011, // strobe high, recovery
        st_rd_low    = 4'b0100, // bus read output enable low
        st_busy      = 4'b0101, // wait for engine ready
        st_sleep     = 4'b0110, // reset pin held low
        st_done      = 4'b0111
    } fpt_state_type;

    fpt_state_type             state_q;
    logic [1:0]                step_q;      // write index within a sequence
    fpt_pkg::fpt_req_type      cur_q;       // captured request
    logic                      tmr_load;
    logic [fpt_pkg::cnt_w-1:0] tmr_val;
    logic                      tmr_done;
    logic                      aborted_q;    // operation lost to reset

    fpt_timer fpt_timer_i (
        .mclk  (mclk),
        .rst   (rst),
        .load  (tmr_load),
        .value (tmr_val),
        .done  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // timer load requests, tied to state entries
    always_comb begin
        tmr_load = 1'b0;
        tmr_val  = '0;
        case (state_q)
            st_idle: begin
                if (req_valid && req.op != fpt_pkg::op_sleep) begin
                    tmr_load = 1'b1;
                    tmr_val  = fpt_pkg::cnt_w'(fpt_pkg::pulse_cyc);
                end
            end
            st_wr_low: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val  = fpt_pkg::cnt_w'(fpt_pkg::gap_cyc);
                end
            end
            st_wr_high: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val  = fpt_pkg::cnt_w'(fpt_pkg::pulse_cyc);
                end
            end
            st_busy: begin
                // fresh strobe width for the status read that follows
                if (tmr_done && ready_busy_n && supply_ok) begin
                    tmr_load = 1'b1;
                    tmr_val  = fpt_pkg::cnt_w'(fpt_pkg::pulse_cyc);
                end
            end
            st_sleep: begin
                // wake-up wait is the longer write interval
                tmr_load = 1'b1;
                tmr_val  = fpt_pkg::cnt_w'(fpt_pkg::wake_write_cyc);
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    // number of writes and their data per operation
    function automatic logic [15:0] wr_data(input fpt_pkg::fpt_req_type r, input logic [1:0] s);
        logic [15:0] d;
        d = 16'h0000;
        case (r.op)
            fpt_pkg::op_write: d = (s == 2'd0) ? {8'h00, fpt_pkg::cmd_write_setup} : r.data;
            fpt_pkg::op_erase: d = (s == 2'd0) ? {8'h00, fpt_pkg::cmd_erase_setup}
                                               : {8'h00, fpt_pkg::cmd_erase_conf};
            fpt_pkg::op_clear: d = {8'h00, fpt_pkg::cmd_clear_status};
            default:           d = {8'h00, fpt_pkg::cmd_read_array};
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // main sequencing
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= st_sleep;
            step_q  <= 2'd0;
            cur_q   <= '0;
        end else begin
            case (state_q)
                st_sleep: begin
                    // leave deep power-down only on an explicit wake
                    if (req_valid && req.op == fpt_pkg::op_wake) begin
                        state_q <= st_wake_wait;
                    end
                end
                st_wake_wait: begin
                    if (tmr_done) begin
                        state_q <= st_idle;
                    end
                end
                st_idle: begin
                    if (req_valid) begin
                        cur_q  <= req;
                        step_q <= 2'd0;
                        if (req.op == fpt_pkg::op_sleep) begin
                            state_q <= st_sleep;
                        end else if (req.op == fpt_pkg::op_wake) begin
                            state_q <= st_done;
                        end else begin
                            // every op starts by a command write
                            state_q <= st_wr_low;
                        end
                    end
                end
                st_wr_low: begin
                    if (tmr_done) begin
                        state_q <= st_wr_high;
                    end
                end
                st_wr_high: begin
                    if (tmr_done) begin
                        if ((cur_q.op == fpt_pkg::op_write || cur_q.op == fpt_pkg::op_erase)
                            && step_q == 2'd0) begin
                            step_q  <= 2'd1;
                            state_q <= st_wr_low;
                        end else if (cur_q.op == fpt_pkg::op_write
                                     || cur_q.op == fpt_pkg::op_erase) begin
                            state_q <= st_busy;
                        end else if (cur_q.op == fpt_pkg::op_read) begin
                            state_q <= st_rd_low;
                        end else begin
                            state_q <= st_done;
                        end
                    end
                end
                st_busy: begin
                    // supply loss: pull reset to abort, device drops the op
                    if (!supply_ok) begin
                        state_q <= st_sleep;
                    end else if (tmr_done && ready_busy_n) begin
                        // read status; read-array is written only at the start of the next read op
                        cur_q.op <= fpt_pkg::op_read;
                        step_q   <= 2'd2;
                        state_q  <= st_rd_low;
                    end
                end
                st_rd_low: begin
                    if (tmr_done) begin
                        state_q <= st_done;
                    end
                end
                st_done: begin
                    state_q <= st_idle;
                end
                default: begin
                    state_q <= st_sleep;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins, all registered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reset_powerdown_n <= 1'b0;
            fl_chip_en_n      <= 1'b1;
            fl_write_en_n     <= 1'b1;
            fl_out_en_n       <= 1'b1;
            fl_dq_oe          <= 1'b0;
            fl_dq_out         <= 16'h0000;
            fl_addr           <= 18'h00000;
        end else begin
            reset_powerdown_n <= (state_q != st_sleep) && supply_ok;
            fl_chip_en_n      <= !(state_q == st_wr_low || state_q == st_rd_low);
            fl_write_en_n     <= !(state_q == st_wr_low);
            fl_out_en_n       <= !(state_q == st_rd_low);
            fl_dq_oe          <= (state_q == st_wr_low || state_q == st_wr_high);
            fl_dq_out         <= wr_data(cur_q, step_q);
            fl_addr           <= cur_q.addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user answers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_ready    <= 1'b0;
            rsp_valid    <= 1'b0;
            rsp          <= '0;
            aborted_q    <= 1'b0;
        end else begin
            req_ready    <= (state_q == st_idle || state_q == st_sleep) && !req_valid;
            // an abort also ends the operation, so the user is answered
            rsp_valid    <= (state_q == st_done) || (state_q == st_busy && !supply_ok);
            // supply loss during the st_busy wait is reported as an abort
            if (state_q == st_busy && !supply_ok) begin
                aborted_q <= 1'b1;
            end else if (state_q == st_idle && req_valid) begin
                aborted_q <= 1'b0;
            end
            if (state_q == st_rd_low && tmr_done) begin
                rsp.data         <= fl_dq_in;
                rsp.supply_fault <= fl_dq_in[fpt_pkg::supply_flt_bit];
                rsp.write_error  <= fl_dq_in[fpt_pkg::write_err_bit];
                rsp.erase_error  <= fl_dq_in[fpt_pkg::erase_err_bit];
            end
            rsp.aborted <= aborted_q || (state_q == st_busy && !supply_ok);
        end
    end
endmodule
`default_nettype wire

// ==== hdl/fpt_pkg.sv ====
// package: constants and carrier types for the flash power-transition host controller
package fpt_pkg;
    // command codes written on the data bus
    localparam logic [7:0] cmd_read_array   = 8'hff;
    localparam logic [7:0] cmd_erase_setup  = 8'h20;
    localparam logic [7:0] cmd_erase_conf   = 8'hd0;
    localparam logic [7:0] cmd_write_setup  = 8'h40;
    localparam logic [7:0] cmd_read_status  = 8'h70;
    localparam logic [7:0] cmd_clear_status = 8'h50;
    // status bit positions
    localparam int unsigned ready_bit       = 7;
    localparam int unsigned erase_err_bit   = 5;
    localparam int unsigned write_err_bit   = 4;
    localparam int unsigned supply_flt_bit  = 3;
    // clock rate and timings
    localparam int unsigned clk_mhz         = 250;
    localparam int unsigned wake_read_ns    = 600;  // wake_to_read_delay, plain default
    localparam int unsigned wake_write_ns   = 1000; // wake_to_write_delay, plain default
    localparam int unsigned pulse_ns        = 60;   // write enable low width
    localparam int unsigned gap_ns          = 40;   // write enable high / recovery
    localparam int unsigned wake_read_cyc   = (wake_read_ns * clk_mhz + 999) / 1000;
    localparam int unsigned wake_write_cyc  = (wake_write_ns * clk_mhz + 999) / 1000;
    localparam int unsigned pulse_cyc       = (pulse_ns * clk_mhz + 999) / 1000;
    localparam int unsigned gap_cyc         = (gap_ns * clk_mhz + 999) / 1000;
    localparam int unsigned cnt_w           = 12;
    // reset values
    localparam logic [7:0]  status_rst      = 8'h00;

    // user operation codes
    typedef enum logic [2:0] {
        op_read   = 3'b000,
        op_write  = 3'b001,
        op_erase  = 3'b010,
        op_sleep  = 3'b011,
        op_wake   = 3'b100,
        op_clear  = 3'b101
    } fpt_op_type;

    // user request carrier
    typedef struct packed {
        fpt_op_type  op;
        logic [17:0] addr;
        logic [15:0] data;
    } fpt_req_type;

    // outcome carrier
    typedef struct packed {
        logic        supply_fault;
        logic        write_error;
        logic        erase_error;
        logic        aborted;
        logic [15:0] data;
    } fpt_rsp_type;
endpackage

// ==== hdl/fpt_timer.sv ====
// file: down-counting wait timer used for bus strobes and wake-up intervals
`timescale 1ns/10ps
`default_nettype none
module fpt_timer (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      load,
    input  wire logic [fpt_pkg::cnt_w-1:0] value,
    output var  logic                      done
);
    logic [fpt_pkg::cnt_w-1:0] cnt_q; // cycles left

    // count down to zero, reload on demand
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // combinational so the caller sees expiry in the same cycle;
    // done must not depend on load, the caller reloads on done
    always_comb begin
        done = (cnt_q == '0);
    end
endmodule
`default_nettype wire

// ==== tb/fpt_host_asserts.sv ====
// checker: pin timing relations of the flash host controller
`timescale 1ns/10ps
`default_nettype none
module fpt_host_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic supply_ok,
    input wire logic rsp_valid,
    input wire logic fl_dq_oe,
    input wire logic fl_chip_en_n,
    input wire logic fl_write_en_n,
    input wire logic fl_out_en_n,
    input wire logic reset_powerdown_n,
    input wire logic ready_busy_n
);
    localparam int WR_MIN = fpt_pkg::wake_read_cyc - 1;
    localparam int WW_MIN = fpt_pkg::wake_write_cyc - 1;
    logic [8:0] wake_q; // cycles since reset pin rose
    ////////////////////////////////////////////////////////////////
    // wake counter saturates so a long idle never wraps it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wake_q <= 9'h000;
        end else if (!reset_powerdown_n) begin
            wake_q <= 9'h000;
        end else if (wake_q != 9'h1ff) begin
            wake_q <= wake_q + 9'h001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_supply_loss_reset: assert property (!supply_ok |-> ##[0:2] !reset_powerdown_n)
        else $error("reset pin kept high after supply loss");
    a_read_wake_wait: assert property (!fl_out_en_n |-> wake_q >= WR_MIN)
        else $error("read strobe too soon after wake");
    a_write_wake_wait: assert property (!fl_write_en_n |-> wake_q >= WW_MIN)
        else $error("write strobe too soon after wake");
    a_write_both_en: assert property (!fl_write_en_n |-> !fl_chip_en_n && fl_dq_oe)
        else $error("write strobe without chip enable or data drive");
    a_no_bus_fight: assert property (!fl_out_en_n |-> !fl_dq_oe && fl_write_en_n)
        else $error("read strobe while driving bus");
    a_busy_no_write: assert property (!ready_busy_n && reset_powerdown_n |-> fl_write_en_n)
        else $error("command written while device busy");
    a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
        else $error("response pulse longer than one cycle");
    cover property (!supply_ok ##[1:8] !reset_powerdown_n);
    cover property ($rose(ready_busy_n));
    cover property (rsp_valid);
endmodule
bind fpt_host fpt_host_asserts fpt_host_asserts_i (.mclk, .rst, .supply_ok, .rsp_valid,
    .fl_dq_oe, .fl_chip_en_n, .fl_write_en_n, .fl_out_en_n, .reset_powerdown_n, .ready_busy_n);
`default_nettype wire

// ==== tb/fpt_flash_model.sv ====
// model: behavioural flash seen at its pins, clocked for busy time
`timescale 1ns/10ps
`default_nettype none
module fpt_flash_model #(parameter int BUSY_CYC = 24) (
    input  wire logic        mclk,
    input  wire logic [17:0] fl_addr,
    input  wire logic [15:0] fl_dq_out,
    input  wire logic        fl_chip_en_n,
    input  wire logic        fl_write_en_n,
    input  wire logic        fl_out_en_n,
    input  wire logic        reset_powerdown_n,
    input  wire logic        vpp_ok,
    output logic [15:0]      fl_dq_in,
    output logic             ready_busy_n
);
    logic [15:0] mem [0:255];   // small window of the array
    logic [7:0]  st_q;          // sticky error flags
    logic        stat_q;        // status mode, else array mode
    logic [1:0]  setup_q;       // 1 write armed, 2 erase armed
    logic        kind_q;        // 1 word write, 0 erase
    logic        we_q;
    logic        ce_q;
    logic [17:0] a_q;
    logic [17:0] op_a_q;
    logic [15:0] d_q;
    logic [15:0] op_d_q;
    logic [15:0] last_q = 16'h0000;
    int          busy_q = 0;
    initial foreach (mem[i]) mem[i] = 16'hffff;
    assign ready_busy_n = (busy_q == 0);
    // released bus toggles each cycle, so it never holds the old word
    assign fl_dq_in = (reset_powerdown_n && !fl_chip_en_n && !fl_out_en_n) ?
        (stat_q ? {8'h00, ready_busy_n, st_q[6:0]} : mem[fl_addr[7:0]]) : ~last_q;
    ////////////////////////////////////////////////////////////////
    // commands latch on write strobe rising edge
    always @(posedge mclk) begin
        we_q <= fl_write_en_n;
        ce_q <= fl_chip_en_n;
        a_q <= fl_addr;
        d_q <= fl_dq_out;
        last_q <= fl_dq_in;
        if (!reset_powerdown_n) begin
            st_q <= 8'h00;
            stat_q <= 1'b0;
            setup_q <= 2'd0;
            busy_q <= (busy_q > 2) ? 2 : (busy_q > 0) ? busy_q - 1 : 0;
        end else if (busy_q > 0) begin
            busy_q <= busy_q - 1;
            if (busy_q == 1 && !vpp_ok) begin
                st_q <= st_q | (kind_q ? 8'h18 : 8'h28);
            end else if (busy_q == 1) begin
                mem[op_a_q[7:0]] <= kind_q ? op_d_q : 16'hffff;
            end
        end else if (fl_write_en_n && !we_q && !ce_q) begin
            stat_q <= d_q[7:0] != fpt_pkg::cmd_read_array;
            setup_q <= 2'd0;
            if (setup_q != 2'd0) begin
                kind_q <= setup_q[0];
                op_a_q <= a_q;
                op_d_q <= d_q;
                if (setup_q[0] || d_q[7:0] == fpt_pkg::cmd_erase_conf) busy_q <= BUSY_CYC;
            end else if (d_q[7:0] == fpt_pkg::cmd_clear_status) begin
                st_q <= 8'h00;
            end else if (d_q[7:0] == fpt_pkg::cmd_write_setup) begin
                setup_q <= 2'd1;
            end else if (d_q[7:0] == fpt_pkg::cmd_erase_setup) begin
                setup_q <= 2'd2;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_fpt_host.sv ====
// testbench: flash host controller against the behavioural flash
`timescale 1ns/10ps
`default_nettype none
module tb_fpt_host;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic supply_ok = 1'b1;
    logic vpp_ok = 1'b1;
    fpt_pkg::fpt_req_type req = '0;
    fpt_pkg::fpt_rsp_type rsp;
    logic req_ready, rsp_valid, fl_dq_oe, fl_chip_en_n, fl_write_en_n, fl_out_en_n;
    logic reset_powerdown_n, ready_busy_n;
    logic [17:0] fl_addr;
    logic [15:0] fl_dq_in, fl_dq_out;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    always #2 mclk = ~mclk;
    fpt_host fpt_host_i (.mclk, .rst, .req_valid, .req, .supply_ok, .req_ready, .rsp_valid,
        .rsp, .fl_addr, .fl_dq_in, .fl_dq_out, .fl_dq_oe, .fl_chip_en_n, .fl_write_en_n,
        .fl_out_en_n, .reset_powerdown_n, .ready_busy_n);
    fpt_flash_model fpt_flash_model_i (.mclk, .fl_addr, .fl_dq_out, .fl_chip_en_n,
        .fl_write_en_n, .fl_out_en_n, .reset_powerdown_n, .vpp_ok, .fl_dq_in, .ready_busy_n);
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // hold request until taken, then wait for the answer
    task automatic do_op(input fpt_pkg::fpt_op_type op, input logic [17:0] a,
        input logic [15:0] d);
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a, data: d};
        do @(negedge mclk); while (req_ready !== 1'b1);
        @(posedge mclk);
        req_valid <= 1'b0;
        do @(negedge mclk); while (rsp_valid !== 1'b1
            && !((op == fpt_pkg::op_wake || op == fpt_pkg::op_sleep) && req_ready === 1'b1));
    endtask
    function automatic logic [15:0] flags();
        return {13'h0000, rsp.supply_fault, rsp.write_error, rsp.erase_error};
    endfunction
    task automatic t_write(input logic [15:0] d);
        do_op(fpt_pkg::op_write, 18'h00005, d);
        check("write flags", flags(), 16'h0000);
        do_op(fpt_pkg::op_read, 18'h00005, 16'h0000);
        check("readback", rsp.data, d);
        $display("test write %h done", d);
    endtask
    task automatic t_sleep();
        do_op(fpt_pkg::op_sleep, 18'h00000, 16'h0000);
        check("pin low in sleep", {15'h0000, reset_powerdown_n}, 16'h0000);
        do_op(fpt_pkg::op_wake, 18'h00000, 16'h0000);
        do_op(fpt_pkg::op_read, 18'h00005, 16'h0000);
        check("read after wake", rsp.data, 16'h1234);
        $display("test sleep and wake done");
    endtask
    task automatic t_erase();
        do_op(fpt_pkg::op_erase, 18'h00005, 16'h0000);
        do_op(fpt_pkg::op_read, 18'h00005, 16'h0000);
        check("erased word", rsp.data, 16'hffff);
        $display("test erase done");
    endtask
    task automatic t_fault();
        vpp_ok <= 1'b0;
        do_op(fpt_pkg::op_write, 18'h00005, 16'h0bad);
        check("write fault", flags(), 16'h0006);
        do_op(fpt_pkg::op_clear, 18'h00000, 16'h0000);
        do_op(fpt_pkg::op_erase, 18'h00005, 16'h0000);
        check("erase fault", flags(), 16'h0005);
        do_op(fpt_pkg::op_read, 18'h00005, 16'h0000);
        check("fault kept data", rsp.data, 16'hffff);
        vpp_ok <= 1'b1;
        $display("test supply fault done");
    endtask
    task automatic t_abort();
        fork
            do_op(fpt_pkg::op_write, 18'h00005, 16'h1357);
            begin
                wait (ready_busy_n === 1'b0);
                @(posedge mclk);
                supply_ok <= 1'b0;
            end
        join
        check("aborted", {15'h0000, rsp.aborted}, 16'h0001);
        @(posedge mclk);
        supply_ok <= 1'b1;
        do_op(fpt_pkg::op_wake, 18'h00000, 16'h0000);
        $display("test abort done");
        t_write(16'h55aa);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        do_op(fpt_pkg::op_wake, 18'h00000, 16'h0000);
        check("ready after wake", {15'h0000, req_ready}, 16'h0001);
        t_write(16'h1234);
        t_sleep();
        t_erase();
        t_fault();
        t_abort();
        give_verdict();
    end
endmodule
`default_nettype wire
